//--- hdl/ict_pkg.sv
// Purpose: constants shared by the interrupter cycle timer
// Assumes: 20 MHz mclk, AXI4-Lite register access with 32-bit data
// Notes: date-time keys are packed so that a plain compare orders them
package ict_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int AW = 8;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ONOFF = 8'h04;
    localparam logic [7:0] OFS_START = 8'h08;
    localparam logic [7:0] OFS_STOP = 8'h0C;
    localparam logic [7:0] OFS_NOW = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_EDIT = 8'h18;
    // onoff field positions
    localparam int ON_SEC_LSB = 0;
    localparam int OFF_SEC_LSB = 8;
    localparam int ON_TENTH_LSB = 16;
    localparam int SUBSEC_BIT = 24;
    // status and edit bits
    localparam int ST_CLOSED_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_RUN_BIT = 2;
    localparam int ED_BEGIN_BIT = 0;
    localparam int ED_CONFIRM_BIT = 1;
    // limits and reset values
    localparam logic [5:0] SEC_MIN = 6'h01;
    localparam logic [5:0] SEC_MAX = 6'h3C;
    localparam logic [3:0] TENTH_MIN = 4'h2;
    localparam logic [3:0] TENTH_MAX = 4'h8;
    localparam logic [15:0] MS_PER_SEC = 16'h03E8;
    localparam logic [15:0] MS_PER_TENTH = 16'h0064;
    localparam logic [15:0] SUBSEC_PERIOD_MS = 16'h03E8;
    localparam int DT_W = 27;
    localparam logic [26:0] START_RST = 27'h0000000;
    localparam logic [26:0] STOP_RST = 27'h0000001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // date-time field under edit
    typedef enum logic [2:0] {
        ICT_ED_IDLE = 3'b000,
        ICT_ED_HOUR = 3'b001,
        ICT_ED_MIN = 3'b010,
        ICT_ED_DAY = 3'b011,
        ICT_ED_MONTH = 3'b100,
        ICT_ED_YEAR = 3'b101
    } ict_edit_t;
endpackage : ict_pkg

//--- hdl/ict_top.sv
// Purpose: on/off cycle timer driving a protection current interrupter
// Assumes: date-time keys {year[26:20],month[19:16],day[15:11],hour[10:6],min[5:0]}
// Notes: current time is written by software into the now register
module ict_top #(
    parameter int unsigned TICK_CYCLES = ict_pkg::TICK_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // axi4-lite write
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ict_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ict_pkg::AW-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // interrupter side
    input wire logic ext_closed,
    output logic relay_closed,
    output logic run_led,
    output logic window_err,
    output logic [2:0] edit_field
);
    import ict_pkg::*;

    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, bvalid_r, bvalid_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [AW-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, wd;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic internal_r, internal_nxt, subsec_r, subsec_nxt, closed_r, closed_nxt;
    logic [5:0] on_sec_r, on_sec_nxt, off_sec_r, off_sec_nxt, ws_on, ws_off;
    logic [3:0] tenth_r, tenth_nxt, wt;
    logic [DT_W-1:0] start_r, start_nxt, stop_r, stop_nxt, now_r, now_nxt;
    ict_edit_t field_r, field_nxt;
    logic [31:0] tick_r, tick_nxt;
    logic [15:0] ms_r, ms_nxt, on_ms, off_ms, dur_ms;
    logic do_wr, wr_onoff, in_window, running, err;

    assign do_wr = aw_full_r && w_full_r && !bvalid_r;
    assign wd = wdata_r & {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wr_onoff = do_wr && awaddr_r == OFS_ONOFF;
    assign err = stop_r <= start_r;
    assign in_window = now_r >= start_r && now_r < stop_r;
    assign running = internal_r && !err && in_window;
    // sub-second off time is derived so the period always stays fixed
    assign on_ms = subsec_r ? 16'(tenth_r * MS_PER_TENTH) : 16'(on_sec_r * MS_PER_SEC);
    assign off_ms = subsec_r ? 16'(SUBSEC_PERIOD_MS - on_ms) : 16'(off_sec_r * MS_PER_SEC);
    assign dur_ms = closed_r ? on_ms : off_ms;
    assign ws_on = wd[ON_SEC_LSB +: 6];
    assign ws_off = wd[OFF_SEC_LSB +: 6];
    assign wt = wd[ON_TENTH_LSB +: 4];

    // bus handshakes; address and data may arrive in either order
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (do_wr) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (awaddr_r <= OFS_EDIT && awaddr_r[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (s_axi_araddr)
                OFS_CTRL: rdata_nxt = {31'h00000000, internal_r};
                OFS_ONOFF: rdata_nxt = {7'h00, subsec_r, 4'h0, tenth_r, 2'h0, off_sec_r,
                                        2'h0, on_sec_r};
                OFS_START: rdata_nxt = {5'h00, start_r};
                OFS_STOP: rdata_nxt = {5'h00, stop_r};
                OFS_NOW: rdata_nxt = {5'h00, now_r};
                OFS_STATUS: rdata_nxt = {29'h00000000, running, err, closed_r};
                OFS_EDIT: rdata_nxt = {29'h00000000, field_r};
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // settings written by software
    always_comb begin
        internal_nxt = internal_r;
        subsec_nxt = subsec_r;
        on_sec_nxt = on_sec_r;
        off_sec_nxt = off_sec_r;
        tenth_nxt = tenth_r;
        start_nxt = start_r;
        stop_nxt = stop_r;
        now_nxt = now_r;
        field_nxt = field_r;
        if (do_wr) begin
            case (awaddr_r)
                OFS_CTRL: internal_nxt = wd[0];
                OFS_ONOFF: begin
                    // stepping past sixty seconds lands in the sub-second range
                    subsec_nxt = wd[SUBSEC_BIT] || ws_on > SEC_MAX || ws_off > SEC_MAX;
                    on_sec_nxt = ws_on < SEC_MIN ? SEC_MIN : (ws_on > SEC_MAX ? SEC_MAX : ws_on);
                    off_sec_nxt = ws_off < SEC_MIN ? SEC_MIN
                                : (ws_off > SEC_MAX ? SEC_MAX : ws_off);
                    tenth_nxt = (wt < TENTH_MIN || wt > TENTH_MAX) ? TENTH_MIN : wt;
                end
                OFS_START: start_nxt = wd[DT_W-1:0];
                OFS_STOP: stop_nxt = wd[DT_W-1:0];
                OFS_NOW: now_nxt = wd[DT_W-1:0];
                OFS_EDIT: begin
                    // confirm walks the marker; begin restarts it on the hour
                    if (wd[ED_BEGIN_BIT]) begin
                        field_nxt = ICT_ED_HOUR;
                    end else if (wd[ED_CONFIRM_BIT]) begin
                        case (field_r)
                            ICT_ED_HOUR: field_nxt = ICT_ED_MIN;
                            ICT_ED_MIN: field_nxt = ICT_ED_DAY;
                            ICT_ED_DAY: field_nxt = ICT_ED_MONTH;
                            ICT_ED_MONTH: field_nxt = ICT_ED_YEAR;
                            default: field_nxt = ICT_ED_IDLE;
                        endcase
                    end
                end
                default: ;
            endcase
        end
    end

    // interrupter sequencing; a changed setting takes hold in the phase in progress
    always_comb begin
        tick_nxt = tick_r + 32'h00000001;
        ms_nxt = ms_r;
        closed_nxt = closed_r;
        if (!internal_r) begin
            closed_nxt = ext_closed;
            ms_nxt = 16'h0000;
            tick_nxt = 32'h00000000;
        end else if (!running) begin
            closed_nxt = 1'b1;
            ms_nxt = 16'h0000;
            tick_nxt = 32'h00000000;
        end else if (ms_r >= dur_ms) begin
            // a shortened setting ends the phase in progress at once
            tick_nxt = 32'h00000000;
            ms_nxt = 16'h0000;
            closed_nxt = !closed_r;
        end else if (tick_r >= TICK_CYCLES - 1) begin
            tick_nxt = 32'h00000000;
            if (ms_r + 16'h0001 >= dur_ms) begin
                ms_nxt = 16'h0000;
                closed_nxt = !closed_r;
            end else begin
                ms_nxt = ms_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            {aw_full_r, w_full_r, bvalid_r, rvalid_r, internal_r, subsec_r} <= 6'h00;
            {awaddr_r, wdata_r, wstrb_r, rdata_r} <= 76'h0;
            {bresp_r, rresp_r} <= {RESP_OKAY, RESP_OKAY};
            {on_sec_r, off_sec_r, tenth_r} <= {SEC_MIN, SEC_MIN, TENTH_MIN};
            {start_r, stop_r, now_r} <= {START_RST, STOP_RST, START_RST};
            field_r <= ICT_ED_IDLE;
            {tick_r, ms_r, closed_r} <= {32'h00000000, 16'h0000, 1'b1};
        end else begin
            {aw_full_r, w_full_r, awaddr_r} <= {aw_full_nxt, w_full_nxt, awaddr_nxt};
            {wdata_r, wstrb_r, bvalid_r} <= {wdata_nxt, wstrb_nxt, bvalid_nxt};
            {bresp_r, rvalid_r} <= {bresp_nxt, rvalid_nxt};
            {rdata_r, rresp_r} <= {rdata_nxt, rresp_nxt};
            {internal_r, subsec_r, tenth_r} <= {internal_nxt, subsec_nxt, tenth_nxt};
            {on_sec_r, off_sec_r} <= {on_sec_nxt, off_sec_nxt};
            {start_r, stop_r, now_r} <= {start_nxt, stop_nxt, now_nxt};
            field_r <= field_nxt;
            {tick_r, ms_r, closed_r} <= {tick_nxt, ms_nxt, closed_nxt};
        end
    end

    // outputs
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready = !w_full_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign relay_closed = closed_r;
    assign run_led = closed_r;
    assign window_err = err;
    assign edit_field = field_r;

    // checks
    property p_led_on;
        @(posedge mclk) disable iff (sys_rst) relay_closed |-> run_led;
    endproperty
    a_led_on: assert property (p_led_on) else $error("run led dark while closed");
    property p_led_off;
        @(posedge mclk) disable iff (sys_rst) !relay_closed |-> !run_led;
    endproperty
    a_led_off: assert property (p_led_off) else $error("run led lit while open");
    property p_ext;
        @(posedge mclk) disable iff (sys_rst) !internal_r |=> relay_closed == $past(ext_closed);
    endproperty
    a_ext: assert property (p_ext) else $error("external mode not followed");
    property p_dur;
        @(posedge mclk) disable iff (sys_rst) running && !subsec_r && !$past(wr_onoff)
            |-> ms_r < dur_ms && dur_ms >= 16'h03E8 && dur_ms <= 16'hEA60;
    endproperty
    a_dur: assert property (p_dur) else $error("seconds phase out of range");
    property p_sub;
        @(posedge mclk) disable iff (sys_rst) wr_onoff && ws_on > SEC_MAX |=> subsec_r
            && tenth_r >= TENTH_MIN && tenth_r <= TENTH_MAX;
    endproperty
    a_sub: assert property (p_sub) else $error("no switch to sub-second range");
    property p_period;
        @(posedge mclk) disable iff (sys_rst) subsec_r |-> on_ms + off_ms == 16'h03E8;
    endproperty
    a_period: assert property (p_period) else $error("sub-second period not 1000 ms");
    property p_derive;
        @(posedge mclk) disable iff (sys_rst) subsec_r |-> on_ms == 16'(tenth_r * 16'h0064)
            && on_ms >= 16'h00C8 && on_ms <= 16'h0320;
    endproperty
    a_derive: assert property (p_derive) else $error("sub-second on time wrong");
    property p_start;
        @(posedge mclk) disable iff (sys_rst) do_wr && awaddr_r == OFS_START
            |=> start_r == $past(wd[DT_W-1:0]);
    endproperty
    a_start: assert property (p_start) else $error("start time not held");
    property p_stop;
        @(posedge mclk) disable iff (sys_rst) do_wr && awaddr_r == OFS_STOP
            |=> stop_r == $past(wd[DT_W-1:0]);
    endproperty
    a_stop: assert property (p_stop) else $error("stop time not held");
    property p_err;
        @(posedge mclk) disable iff (sys_rst) stop_r <= start_r |-> window_err && !running;
    endproperty
    a_err: assert property (p_err) else $error("bad window accepted");
    property p_edit;
        @(posedge mclk) disable iff (sys_rst) do_wr && awaddr_r == OFS_EDIT && !wd[0] && wd[1]
            && field_r == ICT_ED_HOUR |=> field_r == ICT_ED_MIN;
    endproperty
    a_edit: assert property (p_edit) else $error("edit marker did not advance");
    property p_window;
        @(posedge mclk) disable iff (sys_rst) internal_r && !running |=> relay_closed;
    endproperty
    a_window: assert property (p_window) else $error("cycling outside window");
    c_toggle: cover property (@(posedge mclk) disable iff (sys_rst) running && $fell(closed_r));
    c_subsec: cover property (@(posedge mclk) disable iff (sys_rst) subsec_r && $rose(closed_r));
    c_err: cover property (@(posedge mclk) disable iff (sys_rst) $rose(window_err));
endmodule : ict_top

//--- bench/ict_relay_model.sv
// Purpose: far-side model of the external interrupter request line
// Assumes: bench sets the hold length and enables toggling
// Notes: the request toggles so every level is exercised, never left unknown
module ict_relay_model (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control from the bench
    input wire logic toggle_en,
    input wire logic [7:0] hold_cycles,
    // contact request towards the timer
    output logic ext_closed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_r;

    // toggle after each hold, changing right after the edge like a real source
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ext_closed <= 1'b1;
            cnt_r <= 8'h00;
        end else if (toggle_en && cnt_r >= hold_cycles) begin
            ext_closed <= ~ext_closed;
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule : ict_relay_model

//--- bench/tb.sv
// Purpose: self-checking bench for the interrupter cycle timer
// Assumes: TICK_CYCLES is 2, so one millisecond is two clocks
// Notes: phase lengths are rounded to whole milliseconds
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ict_pkg::*;
    localparam int TK = 2;
    logic mclk = 1'b0, sys_rst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic ext_closed, relay_closed, run_led, window_err;
    logic [2:0] edit_field;
    logic toggle_en = 1'b0;
    logic [7:0] hold_cycles = 8'h03;
    logic [31:0] lfsr = 32'h70E02A2A;
    int num_errors = 0, checks_done = 0, cycles = 0;

    // short tick keeps one second at two thousand clocks
    ict_top #(.TICK_CYCLES(TK)) uut (
        .mclk(mclk), .sys_rst(sys_rst),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .ext_closed(ext_closed),
        .relay_closed(relay_closed), .run_led(run_led),
        .window_err(window_err), .edit_field(edit_field)
    );
    ict_relay_model partner (
        .mclk(mclk), .sys_rst(sys_rst), .toggle_en(toggle_en),
        .hold_cycles(hold_cycles), .ext_closed(ext_closed)
    );

    // 20 MHz clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    // hang guard, well above the longest expected run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    function automatic int ms(input int c);
        return (c + TK / 2) / TK;
    endfunction : ms

    // each channel released only at the edge that takes it; ready lines stay high
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axi_rd

    // counts clocks while the contact holds one level; lamp must track it
    task automatic phase_len(input logic lvl, output int c);
        c = 0;
        while (relay_closed === lvl) begin
            chk("run_led", run_led, relay_closed);
            @(posedge mclk);
            c++;
        end
    endtask : phase_len

    // skips the partial phases, then times one open and one closed phase
    task automatic measure(output int op, output int cl);
        int x;
        phase_len(1'b0, x);
        phase_len(1'b1, x);
        phase_len(1'b0, op);
        phase_len(1'b1, cl);
    endtask : measure

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [26:0] s;
        logic prev;
        int op, cl, opens;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk("reset_relay", relay_closed, 32'h1);
        chk("reset_led", run_led, 32'h1);
        chk("reset_edit", edit_field, 32'h0);
        // unmapped places answer with an error
        axi_rd(8'h1C, d, r);
        chk("unmapped_data", d, 32'h0);
        chk("unmapped_rresp", r, RESP_SLVERR);
        axi_wr(8'h20, 32'hFFFFFFFF, r);
        chk("unmapped_bresp", r, RESP_SLVERR);
        // external mode: sub-second setting present but ignored
        axi_wr(OFS_ONOFF, 32'h01030000, r);
        lfsr = lfsr_next(lfsr);
        hold_cycles <= {4'h0, lfsr[3:0]};
        toggle_en <= 1'b1;
        @(negedge mclk);
        prev = ext_closed;
        repeat (200) begin
            @(negedge mclk);
            chk("relay_follow", relay_closed, prev);
            chk("led_follow", run_led, relay_closed);
            prev = ext_closed;
        end
        @(posedge mclk);
        toggle_en <= 1'b0;
        // edit marker walks hour, minute, day, month, year, then idle
        axi_wr(OFS_EDIT, 32'h1, r);
        chk("edit_hour", edit_field, 32'h1);
        for (int k = 2; k <= 6; k++) begin
            axi_wr(OFS_EDIT, 32'h2, r);
            axi_rd(OFS_EDIT, d, r);
            chk("edit_read", d, (k == 6) ? 0 : k);
        end
        // random windows: equal and reversed flag, later stop clears
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            s = (lfsr[26:0] >> 1) | 27'h1;
            axi_wr(OFS_START, {5'h0, s}, r);
            axi_wr(OFS_STOP, {5'h0, s}, r);
            chk("err_equal", window_err, 32'h1);
            axi_wr(OFS_STOP, {5'h0, s - 27'h1}, r);
            axi_rd(OFS_STATUS, d, r);
            chk("err_status", d[ST_ERR_BIT], 32'h1);
            axi_wr(OFS_STOP, {5'h0, s + 27'h1}, r);
            chk("err_clear", window_err, 32'h0);
            axi_rd(OFS_START, d, r);
            chk("start_key", d, {5'h0, s});
            axi_rd(OFS_STOP, d, r);
            chk("stop_key", d, {5'h0, s + 27'h1});
        end
        // internal seconds range, on 1 s and off 2 s, inside the window
        axi_wr(OFS_NOW, 32'h96, r);
        axi_wr(OFS_STOP, 32'hC8, r);
        axi_wr(OFS_START, 32'h64, r);
        axi_wr(OFS_ONOFF, 32'h00000201, r);
        axi_wr(OFS_CTRL, 32'h1, r);
        measure(op, cl);
        chk("sec_off", ms(op), 2000);
        chk("sec_on", ms(cl), 1000);
        // sub-second range by passing 60 s, then by the range bit
        for (int i = 0; i < 2; i++) begin
            axi_wr(OFS_ONOFF, i ? 32'h01080505 : 32'h0003003D, r);
            measure(op, cl);
            chk("sub_on", ms(cl), i ? 800 : 300);
            chk("sub_period", ms(op + cl), 1000);
        end
        // stop time is exclusive: contact held closed, request line ignored
        toggle_en <= 1'b1;
        // only the low byte lane is enabled; the other lanes must read back as zero
        s_axi_wstrb <= 4'h1;
        axi_wr(OFS_NOW, 32'hFFFFFFC8, r);
        s_axi_wstrb <= 4'hF;
        axi_rd(OFS_NOW, d, r);
        chk("now_strobe", d, 32'hC8);
        repeat (2) @(posedge mclk);
        opens = 0;
        repeat (3000) begin
            @(posedge mclk);
            if (relay_closed !== 1'b1) opens++;
        end
        chk("outside_closed", opens, 32'h0);
        wrap_up();
    end
endmodule : tb
